// File: verilog/rss_map.svh
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH
// Phase counter layout
`define RSS_PHASE_W 3
`define RSS_PHASE_LAST 3'h7
`define RSS_PHASE_P0 3'h0
`define RSS_PHASE_P1 3'h1
`define RSS_PHASE_P4 3'h4
// Retrace set pulse timing
`define RSS_CLK_NS 8
`define RSS_SET_PULSE_NS 700
`define RSS_SET_CNT_W 7
// Repeat pacing
`define RSS_REP_DIV_W 2
`define RSS_REP_FIRE 2'h3
// Function codes
`define RSS_FUNC_W 4
`define RSS_FUNC_COUNT 4'hE
// Register map (byte addresses)
`define RSS_ADR_W 4
`define RSS_REG_CTRL 4'h0
`define RSS_REG_STATUS 4'h4
`define RSS_CTRL_RESET 2'h3
`define RSS_CTRL_EN_BIT 0
`define RSS_CTRL_REP_BIT 1
`endif

// File: verilog/rss_pkg.sv
package rss_pkg;
	typedef enum logic [2:0] {
		RSS_IDLE = 3'h0,
		RSS_S1 = 3'h1,
		RSS_S2 = 3'h3,
		RSS_S3 = 3'h2,
		RSS_S4 = 3'h6,
		RSS_S5 = 3'h7,
		RSS_S6 = 3'h5,
		RSS_S7 = 3'h4
	} rss_stage_t;
endpackage

// File: verilog/rss_sequencer.sv
`timescale 1ns/100ps
`include "rss_map.svh"
module rss_sequencer (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`RSS_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic permitted_key_strobe,
	input wire logic host_entry_request,
	input wire logic repeat_key,
	input wire logic vertical_drive_pulse,
	input wire logic horiz_drive_enable,
	input wire logic [`RSS_FUNC_W-1:0] key_code,
	input wire logic step_advance,
	input wire logic loop_request,
	input wire logic skip_request_condition,
	output logic phase_p0,
	output logic phase_p1,
	output logic phase_p4,
	output logic line_retrace_set_pulse,
	output logic [7:1] step_outputs,
	output logic [7:1] step_outputs_n,
	output logic sequencer_busy,
	output logic sequencer_busy_n,
	output logic key_command_load,
	output logic write_buffer_clear_entry,
	output logic sequencer_initiate,
	output logic key_input_clear,
	output logic write_buffer_load_key,
	output logic first_step_enable,
	output logic [`RSS_FUNC_W-1:0] key_command,
	output logic suppress_refresh,
	output logic display_blank,
	output logic refresh_reset
);
	localparam int SET_CYC = (`RSS_SET_PULSE_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS;
	localparam logic [`RSS_SET_CNT_W-1:0] SET_LOAD = SET_CYC[`RSS_SET_CNT_W-1:0];

	// ********************
	// Path table and decode
	// ********************
	function automatic rss_pkg::rss_stage_t stage_of(input logic [2:0] idx);
		unique case (idx)
			3'h1: stage_of = rss_pkg::RSS_S1;
			3'h2: stage_of = rss_pkg::RSS_S2;
			3'h3: stage_of = rss_pkg::RSS_S3;
			3'h4: stage_of = rss_pkg::RSS_S4;
			3'h5: stage_of = rss_pkg::RSS_S5;
			3'h6: stage_of = rss_pkg::RSS_S6;
			3'h7: stage_of = rss_pkg::RSS_S7;
			default: stage_of = rss_pkg::RSS_IDLE;
		endcase
	endfunction

	function automatic logic [2:0] idx_of(input rss_pkg::rss_stage_t st);
		unique case (st)
			rss_pkg::RSS_IDLE: idx_of = 3'h0;
			rss_pkg::RSS_S1: idx_of = 3'h1;
			rss_pkg::RSS_S2: idx_of = 3'h2;
			rss_pkg::RSS_S3: idx_of = 3'h3;
			rss_pkg::RSS_S4: idx_of = 3'h4;
			rss_pkg::RSS_S5: idx_of = 3'h5;
			rss_pkg::RSS_S6: idx_of = 3'h6;
			rss_pkg::RSS_S7: idx_of = 3'h7;
		endcase
	endfunction

	// Returns {last stage, loop-back stage}; zero last ends after stage one, as last one does
	function automatic logic [5:0] path_of(input logic [`RSS_FUNC_W-1:0] f);
		unique case (f)
			4'h0: path_of = {3'h2, 3'h0};
			4'h1: path_of = {3'h3, 3'h0};
			4'h2: path_of = {3'h4, 3'h0};
			4'h3: path_of = {3'h5, 3'h0};
			4'h4: path_of = {3'h7, 3'h0};
			4'h5: path_of = {3'h3, 3'h2};
			4'h6: path_of = {3'h4, 3'h2};
			4'h7: path_of = {3'h5, 3'h3};
			4'h8: path_of = {3'h6, 3'h4};
			4'h9: path_of = {3'h7, 3'h5};
			4'hA: path_of = {3'h7, 3'h2};
			4'hB: path_of = {3'h6, 3'h3};
			4'hC: path_of = {3'h1, 3'h0};
			4'hD: path_of = {3'h7, 3'h6};
			default: path_of = {3'h0, 3'h0};
		endcase
	endfunction

	function automatic logic [7:1] onehot(input logic [2:0] idx);
		logic [7:1] v;
		v = '0;
		for (int i = 1; i <= 7; i++) begin
			v[i] = (idx == i[2:0]);
		end
		onehot = v;
	endfunction

	// ********************
	// Declarations
	// ********************
	logic [`RSS_PHASE_W-1:0] phase_r;
	logic p0_r, p1_r, p4_r;
	logic hde_d_r;
	logic [`RSS_SET_CNT_W-1:0] set_cnt_r;
	logic set_pulse_r;
	logic vdp_d_r;
	logic [`RSS_REP_DIV_W-1:0] rep_cnt_r;
	logic entry_r, arm_r, hold_r, load_r;
	logic arm_nxt, load_nxt, entry_en;
	rss_pkg::rss_stage_t stage_r, stage_nxt;
	logic [2:0] idx, last_idx, loop_idx;
	logic busy_r, busy_nxt;
	logic skip_r;
	logic [`RSS_FUNC_W-1:0] cmd_r;
	logic [1:0] ctrl_r;
	logic ack_r;
	logic [31:0] rdat_r;
	logic refr_r;
	logic wb_req;

	// ********************
	// Phase strobes
	// ********************
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			phase_r <= '0;
			p0_r <= 1'b0;
			p1_r <= 1'b0;
			p4_r <= 1'b0;
		end else begin
			phase_r <= (phase_r == `RSS_PHASE_LAST) ? '0 : phase_r + 1'b1;
			p0_r <= (phase_r == `RSS_PHASE_LAST);
			p1_r <= (phase_r == `RSS_PHASE_P0);
			p4_r <= (phase_r == `RSS_PHASE_P4 - 3'h1);
		end
	end

	// ********************
	// Retrace set pulse and repeat pacing
	// ********************
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			hde_d_r <= 1'b0;
			set_cnt_r <= '0;
			set_pulse_r <= 1'b0;
		end else begin
			hde_d_r <= horiz_drive_enable;
			if (horiz_drive_enable && !hde_d_r) begin
				set_cnt_r <= SET_LOAD - 1'b1;
				set_pulse_r <= 1'b1;
			end else if (set_cnt_r != '0) begin
				set_cnt_r <= set_cnt_r - 1'b1;
			end else begin
				set_pulse_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			vdp_d_r <= 1'b0;
			rep_cnt_r <= '0;
		end else begin
			vdp_d_r <= vertical_drive_pulse;
			if (!repeat_key) begin
				rep_cnt_r <= '0;
			end else if (vertical_drive_pulse && !vdp_d_r) begin
				rep_cnt_r <= rep_cnt_r + 1'b1;
			end
		end
	end

	// ********************
	// Entry, arm, hold and load
	// ********************
	always_comb begin
		entry_en = ctrl_r[`RSS_CTRL_EN_BIT] && (permitted_key_strobe || host_entry_request ||
			(ctrl_r[`RSS_CTRL_REP_BIT] && repeat_key && rep_cnt_r == `RSS_REP_FIRE));
		arm_nxt = arm_r;
		load_nxt = load_r;
		if (p0_r) begin
			arm_nxt = entry_r && !hold_r;
			load_nxt = arm_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			entry_r <= 1'b0;
			arm_r <= 1'b0;
			hold_r <= 1'b0;
			load_r <= 1'b0;
		end else begin
			if (!entry_en) begin
				entry_r <= 1'b0;
			end else if (set_pulse_r) begin
				entry_r <= 1'b1;
			end
			arm_r <= arm_nxt;
			load_r <= load_nxt;
			if (!entry_r) begin
				hold_r <= 1'b0;
			end else if (p4_r && arm_r) begin
				hold_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cmd_r <= '0;
		end else if (arm_r && !load_r && p0_r) begin
			cmd_r <= key_code;
		end
	end

	// ********************
	// Stage counter
	// ********************
	always_comb begin
		idx = idx_of(stage_r);
		{last_idx, loop_idx} = path_of(cmd_r);
		stage_nxt = stage_r;
		if (p1_r) begin
			if (load_r && stage_r == rss_pkg::RSS_IDLE) begin
				stage_nxt = rss_pkg::RSS_S1;
			end else if (stage_r != rss_pkg::RSS_IDLE) begin
				// Loop first, so the last stage of a looping path can recycle
				if (loop_request && loop_idx != 3'h0 && idx > loop_idx) begin
					stage_nxt = stage_of(loop_idx);
				end else if (idx >= last_idx) begin
					stage_nxt = rss_pkg::RSS_IDLE;
				end else if (step_advance) begin
					stage_nxt = stage_of(idx + 3'h1);
				end
			end
		end
		busy_nxt = (stage_nxt != rss_pkg::RSS_IDLE) || arm_r || load_r;
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			stage_r <= rss_pkg::RSS_IDLE;
		end else begin
			stage_r <= stage_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			busy_r <= 1'b0;
		end else if (p1_r) begin
			busy_r <= busy_nxt;
		end
	end

	// ********************
	// Skip refresh
	// ********************
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			skip_r <= 1'b0;
			refr_r <= 1'b1;
		end else begin
			if (stage_r == rss_pkg::RSS_S1 && skip_request_condition) begin
				skip_r <= 1'b1;
			end else if (stage_r == rss_pkg::RSS_IDLE && !load_r) begin
				skip_r <= 1'b0;
			end
			refr_r <= skip_r || vertical_drive_pulse;
		end
	end

	// ********************
	// Register bus
	// ********************
	assign wb_req = wb_cyc_i && wb_stb_i;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ack_r <= 1'b0;
			rdat_r <= '0;
		end else begin
			ack_r <= wb_req && !ack_r;
			if (wb_req && !ack_r) begin
				unique case (wb_adr_i)
					`RSS_REG_CTRL: rdat_r <= {30'h0, ctrl_r};
					`RSS_REG_STATUS: rdat_r <= {21'h0, cmd_r, skip_r, busy_r, hold_r, entry_r, idx_of(stage_r)};
					default: rdat_r <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ctrl_r <= `RSS_CTRL_RESET;
		end else if (wb_req && ack_r && wb_we_i && wb_sel_i[0] && wb_adr_i == `RSS_REG_CTRL) begin
			ctrl_r <= wb_dat_i[1:0];
		end
	end

	// ********************
	// Outputs
	// ********************
	assign phase_p0 = p0_r;
	assign phase_p1 = p1_r;
	assign phase_p4 = p4_r;
	assign line_retrace_set_pulse = set_pulse_r;
	assign step_outputs = onehot(idx_of(stage_r));
	assign step_outputs_n = ~step_outputs;
	assign sequencer_busy = busy_r;
	assign sequencer_busy_n = ~busy_r;
	assign key_command_load = arm_r;
	assign write_buffer_clear_entry = arm_r;
	assign sequencer_initiate = arm_r | load_r;
	assign key_input_clear = load_r;
	assign write_buffer_load_key = load_r;
	assign first_step_enable = load_r;
	assign key_command = cmd_r;
	assign suppress_refresh = skip_r;
	assign display_blank = skip_r;
	assign refresh_reset = refr_r;
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// ********************
	// Assertions
	// ********************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	phase_order_a: assert property (p0_r |=> p1_r ##3 p4_r)
		else $error("phase strobes out of order");
	step_on_p1_a: assert property ($changed(stage_r) |-> $past(p1_r))
		else $error("stage moved off phase_p1");
	entry_needs_pulse_a: assert property ($rose(entry_r) |-> $past(set_pulse_r))
		else $error("entry set without retrace pulse");
	arm_on_p0_a: assert property ($rose(arm_r) |-> $past(p0_r) && $past(entry_r))
		else $error("arm set off phase_p0");
	hold_clears_arm_a: assert property (hold_r && p0_r && entry_r |=> !arm_r)
		else $error("arm not cleared by hold");
	hold_on_p4_a: assert property ($rose(hold_r) |-> $past(p4_r) && $past(arm_r))
		else $error("hold set off phase_p4");
	load_follows_arm_a: assert property ($rose(load_r) |-> $past(arm_r) && $past(p0_r))
		else $error("load without arm");
	first_stage_a: assert property (load_r && p1_r && stage_r == rss_pkg::RSS_IDLE
		|=> stage_r == rss_pkg::RSS_S1)
		else $error("stage one not launched");
	skip_set_a: assert property (stage_r == rss_pkg::RSS_S1 && skip_request_condition |=> skip_r ##1 refr_r)
		else $error("skip latch not set");
	busy_track_a: assert property (p1_r && stage_nxt != rss_pkg::RSS_IDLE |=> busy_r)
		else $error("busy missed active stage");
	rep_pace_a: assert property (!repeat_key |=> rep_cnt_r == 2'h0)
		else $error("repeat count not cleared");

	entry_run_c: cover property ($rose(load_r) ##[1:40] stage_r == rss_pkg::RSS_S1);
	loop_back_c: cover property (p1_r && loop_request && stage_r == rss_pkg::RSS_S3 ##1 stage_r == rss_pkg::RSS_S2);
	skip_c: cover property ($rose(skip_r));
	full_path_c: cover property (stage_r == rss_pkg::RSS_S7 ##[1:16] stage_r == rss_pkg::RSS_IDLE);
endmodule

// File: testbench/rss_partner.sv
`timescale 1ns/100ps
// ****
// Decision side model
// ****
module rss_partner (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic slow,
	input wire logic phase_p1,
	output logic step_advance
);
	logic stall_r;
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			stall_r <= 1'h0;
		end else if (phase_p1) begin
			stall_r <= slow & ~stall_r;
		end
	end
	// Withholds step_advance on every other phase_p1 when slow, so each stage left through step_advance waits up to one extra phase period
	assign step_advance = ~stall_r;
endmodule

// File: testbench/retrace_step_sequencer_bench.sv
`timescale 1ns/100ps
`include "rss_map.svh"
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin failures++; $display("wrong value %0t %s", $time, m); end end
module retrace_step_sequencer_bench;
	logic mclk = 1'h0, rst_b = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, slow = 1'h0, p0_q = 1'h0;
	logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF, key_code = 4'h0, key_command;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic permitted_key_strobe = 1'h0, host_entry_request = 1'h0, repeat_key = 1'h0, vertical_drive_pulse = 1'h0;
	logic horiz_drive_enable = 1'h0, loop_request = 1'h0, skip_request_condition = 1'h0, step_advance;
	logic wb_ack_o, phase_p0, phase_p1, phase_p4, line_retrace_set_pulse, sequencer_busy, sequencer_busy_n;
	logic key_command_load, write_buffer_clear_entry, sequencer_initiate, key_input_clear, write_buffer_load_key;
	logic first_step_enable, suppress_refresh, display_blank, refresh_reset;
	logic [7:1] step_outputs, step_outputs_n;
	int failures = 0, comparisons = 0;
	localparam int LAST [16] = '{2, 3, 4, 5, 7, 3, 4, 5, 6, 7, 7, 6, 1, 7, 1, 1};
	localparam int LOOP [16] = '{0, 0, 0, 0, 0, 2, 2, 3, 4, 5, 2, 3, 0, 6, 0, 0};

	rss_sequencer u_rss_sequencer (.mclk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .permitted_key_strobe, .host_entry_request, .repeat_key,
		.vertical_drive_pulse, .horiz_drive_enable, .key_code, .step_advance, .loop_request,
		.skip_request_condition, .phase_p0, .phase_p1, .phase_p4, .line_retrace_set_pulse, .step_outputs,
		.step_outputs_n, .sequencer_busy, .sequencer_busy_n, .key_command_load, .write_buffer_clear_entry,
		.sequencer_initiate, .key_input_clear, .write_buffer_load_key, .first_step_enable, .key_command,
		.suppress_refresh, .display_blank, .refresh_reset);
	rss_partner u_rss_partner (.mclk, .rst_b, .slow, .phase_p1, .step_advance);

	always #4 mclk = ~mclk;
	always @(posedge mclk) p0_q <= phase_p0;

	// ****
	// Helpers
	// ****
	function automatic int exp_steps(input logic [3:0] c, input logic lp);
		return LAST[c] + ((lp && LOOP[c] != 0) ? LAST[c] - LOOP[c] + 1 : 0);
	endfunction
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
	endtask
	function automatic logic pick(input int sel);
		return (sel == 0) ? phase_p0 : (sel == 1) ? line_retrace_set_pulse : key_command_load;
	endfunction
	task automatic wait_for(input int sel, input logic v);
		int n;
		n = 0;
		while (pick(sel) !== v && n < 500) begin
			tick(1);
			n++;
		end
		if (n >= 500) failures++;
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			tick(1);
			n++;
		end while (wb_ack_o !== 1'h1 && n < 50);
		if (n >= 50) failures++;
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		tick(1);
	endtask
	task automatic pulse_hde();
		horiz_drive_enable <= 1'h1;
		tick(1);
		horiz_drive_enable <= 1'h0;
	endtask
	task automatic vpulse();
		vertical_drive_pulse <= 1'h1;
		tick(1);
		vertical_drive_pulse <= 1'h0;
		tick(1);
		`CHK(refresh_reset, 1'h1, "refresh reset")
	endtask
	task automatic quiet(input int k);
		int hits;
		hits = 0;
		repeat (k) begin
			tick(1);
			if (key_command_load !== 1'h0) hits++;
		end
		`CHK(hits, 0, "unwanted arm")
	endtask
	task automatic run(input logic [3:0] c, input int src, input logic lp, input logic sk);
		int n, steps, skips, w;
		logic [7:1] prev;
		logic done;
		key_code <= c;
		skip_request_condition <= sk;
		permitted_key_strobe <= (src == 0);
		host_entry_request <= (src == 1);
		pulse_hde();
		wait_for(2, 1'h1);
		`CHK({p0_q, write_buffer_clear_entry, sequencer_initiate}, 3'h7, "arm")
		w = 0;
		while (key_command_load === 1'h1 && w < 20) begin
			tick(1);
			w++;
		end
		`CHK(w, 8, "arm width")
		`CHK({p0_q, key_input_clear, write_buffer_load_key, first_step_enable, sequencer_initiate}, 5'h1F, "load")
		permitted_key_strobe <= 1'h0;
		host_entry_request <= 1'h0;
		repeat_key <= 1'h0;
		steps = 0;
		skips = 0;
		n = 0;
		done = 1'h0;
		prev = 7'h0;
		while (!(steps > 0 && sequencer_busy === 1'h0) && n < 3000) begin
			tick(1);
			n++;
			if (step_outputs !== prev && step_outputs !== 7'h0) begin
				steps++;
				`CHK({sequencer_busy, sequencer_busy_n, step_outputs_n}, {2'h2, ~step_outputs}, "stage")
			end
			if (loop_request && !step_outputs[LAST[c]]) done = 1'h1;
			loop_request <= lp && !done && step_outputs[LAST[c]];
			prev = step_outputs;
			if ({suppress_refresh, display_blank, refresh_reset} === 3'h7) skips = 1;
		end
		`CHK(steps, exp_steps(c, lp), "steps")
		`CHK(key_command, c, "command")
		`CHK(skips, int'(sk), "skip")
		tick(100);
	endtask
	task automatic summarize();
		if (failures == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// ****
	// Watchdog and main sequence
	// ****
	initial begin
		tick(60000);
		failures++;
		summarize();
	end
	initial begin
		int w;
		void'($urandom(32'h3789));
		tick(6);
		rst_b <= 1'h1;
		tick(1);
		wb(1'h0, `RSS_REG_CTRL, 32'h0);
		`CHK(q, 32'h3, "ctrl reset")
		wb(1'h1, 4'hC, 32'hFFFFFFFF);
		wb(1'h0, 4'hC, 32'h0);
		`CHK(q, 32'h0, "unmapped")
		wb(1'h1, `RSS_REG_STATUS, 32'hFFFFFFFF);
		wb(1'h0, `RSS_REG_STATUS, 32'h0);
		`CHK(q, 32'h0, "status idle")
		wait_for(0, 1'h1);
		tick(1);
		`CHK({phase_p0, phase_p1, phase_p4}, 3'h2, "p1")
		tick(3);
		`CHK({phase_p0, phase_p1, phase_p4}, 3'h1, "p4")
		tick(4);
		`CHK({phase_p0, phase_p1, phase_p4}, 3'h4, "p0")
		pulse_hde();
		wait_for(1, 1'h1);
		w = 0;
		while (line_retrace_set_pulse === 1'h1 && w < 200) begin
			tick(1);
			w++;
		end
		`CHK(w, 88, "set pulse")
		permitted_key_strobe <= 1'h1;
		quiet(100);
		wb(1'h1, `RSS_REG_CTRL, 32'h0);
		pulse_hde();
		quiet(150);
		permitted_key_strobe <= 1'h0;
		wb(1'h1, `RSS_REG_CTRL, 32'h3);
		for (int c = 0; c < 16; c++) run(4'(c), c % 2, 1'h0, c == 9);
		for (int c = 0; c < 16; c++) if (LOOP[c] != 0) run(4'(c), 1, 1'h1, 1'h0);
		repeat_key <= 1'h1;
		vpulse();
		vpulse();
		pulse_hde();
		quiet(120);
		vpulse();
		run(4'h3, 2, 1'h0, 1'h1);
		vpulse();
		repeat (8) begin
			slow <= 1'($urandom % 2);
			run(4'($urandom % 16), $urandom % 2, 1'h0, 1'($urandom % 2));
		end
		summarize();
	end
endmodule
